// file: pkg/serial_access_pkg.sv
package serial_access_pkg;
    // Core clock and register bus timing
    localparam int CLK_NS = 25;
    localparam int FAST_NS = 100;
    localparam int SLOW_NS = 1000;
    localparam int FAST_CYC = FAST_NS / CLK_NS;
    localparam int SLOW_CYC = SLOW_NS / CLK_NS;

    // Frame layout, counted in received bits
    localparam logic [6:0] ADDR_FIRST = 7'h02;
    localparam logic [6:0] ADDR_LAST = 7'h17;
    localparam logic [6:0] DATA_FIRST = 7'h18;
    localparam logic [6:0] DATA_LAST = 7'h37;
    localparam logic [6:0] DATA_LEN = 7'h20;
    localparam logic [6:0] CNT_MAX = 7'h7F;

    // Target field of the 22-bit word address
    localparam int TGT_MSB = 21;
    localparam int TGT_LSB = 14;
    localparam logic [7:0] FAST_A_TGT = 8'h01;
    localparam logic [7:0] FAST_B_TGT = 8'h02;
    localparam logic [21:0] CTRL_ADDR = {FAST_A_TGT, 14'h0000};
    localparam logic [21:0] PAD_ADDR = {FAST_A_TGT, 14'h0001};

    // Field positions and reset values
    localparam int CTRL_ENDIAN_BIT = 0;
    localparam int CTRL_ORDER_BIT = 1;
    localparam int PAD_STAT_BIT = 16;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [1:0] PAD_RST = 2'h0;
    localparam logic [31:0] ERR_WORD = 32'h88888888;

    typedef struct packed {
        logic we;
        logic [21:0] addr;
        logic [31:0] wdata;
    } regReq_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARB = 2'b01,
        ST_BUS = 2'b11
    } coreSt_t;
endpackage

// file: verilog/serial_register_access_slave.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Input sampled on serial clock rise, output changed on its fall.
// - With select high, clock and data input have no effect.
// - Data output enabled only while read data or the error word shifts out, not during padding.
// - Control bit 0 selects byte endianness, bit 1 selects bit order.
// - Read data uses the same ordering as write data.
// - Register read starts right after the last address bit.
// - Configured padding bytes are sent before read data.
// - Late data with padding sends 0x88888888 and sets sticky error.
// - Control register write decodes under any current ordering.
// - Slave answers only when it owns the serial pins.
// - Bus reads end within 125 ns (5 core cycles) fast, 1025 ns (41 core cycles) other targets.
// - Shared slow target: second master waits, round robin; fast exempt.
module serial_register_access_slave
    import serial_access_pkg::*;
(
    input wire logic clk_sys, // Core clock
    input wire logic rst, // Synchronous reset, high
    input wire logic serialClk, // Link clock from host
    input wire logic slaveSelectN, // Frame select, low active
    input wire logic serialDataIn, // Host to device data
    output logic serialDataOut, // Device to host data
    output logic serialDataOutEn, // High while data out is driven
    input wire logic siOwner, // Pins owned by the slave function
    output serial_access_pkg::regReq_t busOut, // Register bus request
    output logic busReq, // Register bus request valid
    input wire logic busAck, // Register bus done, one cycle
    input wire logic [31:0] busRdata, // Register bus read data
    input wire logic peerReq, // Other master wants a shared target
    output logic peerGnt // Other master holds the shared target
);
    import serial_access_pkg::*;

    function automatic logic [31:0] mapWord(input logic [31:0] w,
                                            input logic [1:0] c);
        logic [31:0] v;
        v = w;
        if (c[CTRL_ORDER_BIT]) begin
            for (int i = 0; i < 32; i++) begin
                v[i] = w[31-i];
            end
        end
        if (c[CTRL_ENDIAN_BIT]) begin
            v = {v[7:0], v[15:8], v[23:16], v[31:24]};
        end
        return v;
    endfunction

    logic ownerR;
    logic spiRst;
    logic [1:0] padCfg_r;
    logic [31:0] rdWord_r;
    logic rdAck_r;

    // ==========================================================
    // Link side, receive on rising edge
    // ==========================================================
    // The frame select, or loss of pin ownership, is the reset of this domain: the host clock
    // stands still between frames, so nothing here may wait for it.
    assign spiRst = slaveSelectN | ~ownerR;

    logic [6:0] bitCnt_r, bitCnt_nxt;
    logic rdFlag_r, rdFlag_nxt;
    logic [21:0] addrSh_r, addrSh_nxt;
    logic [31:0] dataSh_r, dataSh_nxt;
    logic rdReq_r, rdReq_nxt;
    logic wrReq_r, wrReq_nxt;
    logic [1:0] padS1_r, padS2_r;
    logic ackS1_r, ackS2_r;

    always_comb begin
        bitCnt_nxt = bitCnt_r;
        rdFlag_nxt = rdFlag_r;
        addrSh_nxt = addrSh_r;
        dataSh_nxt = dataSh_r;
        rdReq_nxt = rdReq_r;
        wrReq_nxt = wrReq_r;
        if (bitCnt_r != CNT_MAX) begin
            bitCnt_nxt = bitCnt_r + 7'h01;
        end
        if (bitCnt_r == 7'h00) begin
            rdFlag_nxt = serialDataIn;
        end else if (bitCnt_r >= ADDR_FIRST && bitCnt_r <= ADDR_LAST) begin
            addrSh_nxt = {addrSh_r[20:0], serialDataIn};
        end else if (bitCnt_r >= DATA_FIRST && bitCnt_r <= DATA_LAST) begin
            dataSh_nxt = {dataSh_r[30:0], serialDataIn};
        end
        if (bitCnt_r == ADDR_LAST && rdFlag_r) begin
            rdReq_nxt = 1'b1;
        end
        if (bitCnt_r == DATA_LAST && !rdFlag_r) begin
            wrReq_nxt = 1'b1;
        end
    end

    always_ff @(posedge serialClk or posedge spiRst) begin
        if (spiRst) begin
            bitCnt_r <= 7'h00;
            rdFlag_r <= 1'b0;
            addrSh_r <= 22'h000000;
            dataSh_r <= 32'h00000000;
            rdReq_r <= 1'b0;
            wrReq_r <= 1'b0;
            padS1_r <= 2'h0;
            padS2_r <= 2'h0;
            ackS1_r <= 1'b0;
            ackS2_r <= 1'b0;
        end else begin
            bitCnt_r <= bitCnt_nxt;
            rdFlag_r <= rdFlag_nxt;
            addrSh_r <= addrSh_nxt;
            dataSh_r <= dataSh_nxt;
            rdReq_r <= rdReq_nxt;
            wrReq_r <= wrReq_nxt;
            padS1_r <= padCfg_r;
            padS2_r <= padS1_r;
            ackS1_r <= rdAck_r;
            ackS2_r <= ackS1_r;
        end
    end

    // ==========================================================
    // Link side, transmit on falling edge
    // ==========================================================
    logic [6:0] txFirst;
    logic [6:0] txStop;
    logic txStart;
    logic padOn;
    logic late;
    logic [31:0] txSh_r, txSh_nxt;
    logic sdoEn_r, sdoEn_nxt;
    logic errLvl_r, errLvl_nxt;

    assign padOn = padS2_r != 2'h0;
    assign txFirst = DATA_FIRST + {2'b00, padS2_r, 3'b000};
    assign txStop = txFirst + DATA_LEN;
    assign txStart = rdFlag_r && bitCnt_r == txFirst;
    assign late = padOn && !ackS2_r;

    always_comb begin
        txSh_nxt = txSh_r;
        sdoEn_nxt = sdoEn_r;
        errLvl_nxt = errLvl_r;
        if (txStart) begin
            txSh_nxt = late ? ERR_WORD : rdWord_r;
            sdoEn_nxt = 1'b1;
            errLvl_nxt = errLvl_r | late;
        end else if (sdoEn_r) begin
            txSh_nxt = {txSh_r[30:0], 1'b0};
            if (bitCnt_r == txStop) begin
                sdoEn_nxt = 1'b0;
            end
        end
    end

    always_ff @(negedge serialClk or posedge spiRst) begin
        if (spiRst) begin
            txSh_r <= 32'h00000000;
            sdoEn_r <= 1'b0;
            errLvl_r <= 1'b0;
        end else begin
            txSh_r <= txSh_nxt;
            sdoEn_r <= sdoEn_nxt;
            errLvl_r <= errLvl_nxt;
        end
    end

    assign serialDataOut = txSh_r[31];
    assign serialDataOutEn = sdoEn_r;

    // ==========================================================
    // Core side: synchronisers and register access
    // ==========================================================
    logic rdS1_r, rdS2_r, wrS1_r, wrS2_r, wrS3_r;
    logic erS1_r, erS2_r, erS3_r;
    coreSt_t state_r, state_nxt;
    regReq_t req_r, req_nxt;
    logic fast_r, fast_nxt;
    logic [5:0] timer_r, timer_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [1:0] padCfg_nxt;
    logic padErr_r, padErr_nxt;
    logic [31:0] rdWord_nxt;
    logic rdAck_nxt;
    logic busReq_r, busReq_nxt;
    logic peerGnt_r, peerGnt_nxt;
    logic lastPeer_r, lastPeer_nxt;
    logic rdStart, wrStart, start, local_, ctrlWr;
    logic ourWant, peerWin;
    logic [31:0] wdMapped;
    logic [7:0] tgt;
    logic [5:0] limit;

    assign rdStart = rdS2_r && !rdAck_r && state_r == ST_IDLE;
    assign wrStart = wrS2_r && !wrS3_r && state_r == ST_IDLE;
    assign start = rdStart | wrStart;
    assign local_ = addrSh_r == CTRL_ADDR || addrSh_r == PAD_ADDR;
    assign ctrlWr = wrStart && addrSh_r == CTRL_ADDR;
    assign wdMapped = mapWord(dataSh_r, ctrl_r);
    assign tgt = addrSh_r[TGT_MSB:TGT_LSB];
    assign ourWant = state_r == ST_ARB && !fast_r;
    assign peerWin = peerReq && (!ourWant || !lastPeer_r);
    assign limit = fast_r ? 6'(FAST_CYC) : 6'(SLOW_CYC);

    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        fast_nxt = fast_r;
        timer_nxt = timer_r;
        ctrl_nxt = ctrl_r;
        padCfg_nxt = padCfg_r;
        padErr_nxt = padErr_r;
        rdWord_nxt = rdWord_r;
        rdAck_nxt = rdAck_r & rdS2_r;
        busReq_nxt = busReq_r;
        peerGnt_nxt = peerGnt_r;
        lastPeer_nxt = lastPeer_r;
        if (ctrlWr) begin
            // Each bit is read where any ordering may have put it
            ctrl_nxt[CTRL_ENDIAN_BIT] = dataSh_r[0] | dataSh_r[7] |
                dataSh_r[24] | dataSh_r[31];
            ctrl_nxt[CTRL_ORDER_BIT] = dataSh_r[1] | dataSh_r[6] |
                dataSh_r[25] | dataSh_r[30];
        end
        if (wrStart && addrSh_r == PAD_ADDR) begin
            padCfg_nxt = wdMapped[1:0];
        end
        if (start && local_) begin
            rdWord_nxt = mapWord({15'h0000, padErr_r, 14'h0000,
                addrSh_r == CTRL_ADDR ? ctrl_r : padCfg_r}, ctrl_r);
            rdAck_nxt = rdStart;
        end else if (start) begin
            req_nxt = '{we: wrStart, addr: addrSh_r, wdata: wdMapped};
            fast_nxt = tgt == FAST_A_TGT || tgt == FAST_B_TGT;
            state_nxt = ST_ARB;
        end
        if (peerGnt_r) begin
            peerGnt_nxt = peerReq;
        end else if (!(state_r == ST_BUS && !fast_r) && peerWin) begin
            peerGnt_nxt = 1'b1;
            lastPeer_nxt = 1'b1;
        end
        unique case (state_r)
            ST_IDLE: begin
            end
            ST_ARB: begin
                if (fast_r || (!peerGnt_r && !peerWin)) begin
                    state_nxt = ST_BUS;
                    busReq_nxt = 1'b1;
                    timer_nxt = 6'h00;
                    lastPeer_nxt = fast_r ? lastPeer_r : 1'b0;
                end
            end
            ST_BUS: begin
                timer_nxt = timer_r + 6'h01;
                if (busAck || timer_r == limit) begin
                    state_nxt = ST_IDLE;
                    busReq_nxt = 1'b0;
                    rdAck_nxt = !req_r.we;
                    // A target that overruns its time reports the error word
                    rdWord_nxt = busAck ? mapWord(busRdata, ctrl_r)
                                        : ERR_WORD;
                end
            end
        endcase
        // Set wins over the clear by a write of one
        if (wrStart && addrSh_r == PAD_ADDR && wdMapped[PAD_STAT_BIT]) begin
            padErr_nxt = 1'b0;
        end
        if ((erS2_r && !erS3_r) ||
            (state_r == ST_BUS && !busAck && timer_r == limit)) begin
            padErr_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ownerR <= 1'b0;
            {rdS1_r, rdS2_r, wrS1_r, wrS2_r, wrS3_r} <= 5'h00;
            {erS1_r, erS2_r, erS3_r} <= 3'h0;
            state_r <= ST_IDLE;
            req_r <= '0;
            fast_r <= 1'b0;
            timer_r <= 6'h00;
            ctrl_r <= CTRL_RST;
            padCfg_r <= PAD_RST;
            padErr_r <= 1'b0;
            rdWord_r <= 32'h00000000;
            rdAck_r <= 1'b0;
            busReq_r <= 1'b0;
            peerGnt_r <= 1'b0;
            lastPeer_r <= 1'b0;
        end else begin
            ownerR <= siOwner;
            {rdS1_r, rdS2_r} <= {rdReq_r, rdS1_r};
            {wrS1_r, wrS2_r, wrS3_r} <= {wrReq_r, wrS1_r, wrS2_r};
            {erS1_r, erS2_r, erS3_r} <= {errLvl_r, erS1_r, erS2_r};
            state_r <= state_nxt;
            req_r <= req_nxt;
            fast_r <= fast_nxt;
            timer_r <= timer_nxt;
            ctrl_r <= ctrl_nxt;
            padCfg_r <= padCfg_nxt;
            padErr_r <= padErr_nxt;
            rdWord_r <= rdWord_nxt;
            rdAck_r <= rdAck_nxt;
            busReq_r <= busReq_nxt;
            peerGnt_r <= peerGnt_nxt;
            lastPeer_r <= lastPeer_nxt;
        end
    end

    assign busOut = req_r;
    assign busReq = busReq_r;
    assign peerGnt = peerGnt_r;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_rdAfterAddr;
        @(posedge serialClk) disable iff (spiRst)
        (bitCnt_r == ADDR_LAST && rdFlag_r) |=> rdReq_r;
    endproperty
    a_rdAfterAddr: assert property (p_rdAfterAddr)
        else $error("read not requested after last address bit");

    property p_quietOut;
        @(negedge serialClk) disable iff (spiRst)
        sdoEn_r |-> rdFlag_r && bitCnt_r >= DATA_FIRST;
    endproperty
    a_quietOut: assert property (p_quietOut)
        else $error("data output driven outside read data");

    property p_errWord;
        @(negedge serialClk) disable iff (spiRst)
        (txStart && late) |=> (txSh_r == ERR_WORD) && errLvl_r;
    endproperty
    a_errWord: assert property (p_errWord)
        else $error("late read did not send error word");

    // The link clock stops after the last write bit, so the frame's
    // count is checked from the core side, where it stands still.
    property p_fullWrite;
        @(posedge clk_sys) disable iff (rst)
        wrStart |-> bitCnt_r == DATA_LAST + 7'h01 && !rdFlag_r;
    endproperty
    a_fullWrite: assert property (p_fullWrite)
        else $error("write raised before all bits received");

    property p_ownerGate;
        @(posedge clk_sys) disable iff (rst)
        $fell(ownerR) |-> ##2 (!rdS2_r && !wrS2_r);
    endproperty
    a_ownerGate: assert property (p_ownerGate)
        else $error("slave active without pin ownership");

    property p_fastLimit;
        @(posedge clk_sys) disable iff (rst)
        (state_r == ST_BUS && fast_r && timer_r == 6'(FAST_CYC))
            |=> state_r == ST_IDLE && !busReq_r;
    endproperty
    a_fastLimit: assert property (p_fastLimit)
        else $error("fast target access overran its time");

    property p_roundRobin;
        @(posedge clk_sys) disable iff (rst)
        (ourWant && peerReq && !peerGnt_r && !lastPeer_r)
            |=> peerGnt_r ##1 (state_r == ST_ARB);
    endproperty
    a_roundRobin: assert property (p_roundRobin)
        else $error("round robin did not favour the other master");

    property p_ctrlDecode;
        @(posedge clk_sys) disable iff (rst)
        (ctrlWr && dataSh_r == 32'h80000000) |=> ctrl_r == 2'h1;
    endproperty
    a_ctrlDecode: assert property (p_ctrlDecode)
        else $error("control write decode depends on ordering");
endmodule
`default_nettype wire

// file: tb/serial_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Serial master seen from the device pins
module serial_host_model (
    output logic serialClk, // Link clock, still between frames
    output logic slaveSelectN, // Frame select
    output logic serialDataIn, // Host to device data
    input wire logic serialDataOut, // Device to host data
    input wire logic serialDataOutEn // Device drives data out
);
    int halfNs = 40;
    initial begin
        serialClk = 1'b0;
        slaveSelectN = 1'b1;
        serialDataIn = 1'b0;
    end
    // Data changes while the clock is low, so every rise sees it settled
    task automatic xfer(input logic rd, input logic [21:0] addr,
        input logic [31:0] wd, input int pad, input int nBits,
        input int pauseNs, output logic [31:0] rdata, output logic enBad);
        logic [55:0] bits;
        int total;
        logic expEn;
        bits = {rd, 1'b0, addr, wd};
        total = rd ? 56 + 8 * pad : 56;
        if (nBits < total) total = nBits;
        rdata = 32'h0;
        enBad = 1'b0;
        slaveSelectN = 1'b0;
        for (int i = 0; i < total; i++) begin
            serialDataIn = (i < 56) ? bits[55 - i] : ~serialDataIn;
            #(halfNs);
            expEn = rd && (i >= 24 + 8 * pad);
            if (serialDataOutEn !== expEn) enBad = 1'b1;
            if (expEn) rdata = {rdata[30:0], serialDataOut};
            serialClk = 1'b1;
            if (i == 23) #(pauseNs);
            #(halfNs);
            serialClk = 1'b0;
        end
        #(halfNs);
        if (serialDataOutEn !== 1'b0) enBad = 1'b1;
        #100 slaveSelectN = 1'b1;
        serialDataIn = ~serialDataIn;
        #100;
    endtask
    // Pins wiggle with select high; the device must not react
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            #37 serialClk = ~serialClk;
            serialDataIn = i[1];
        end
        serialClk = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_serial_register_access_slave.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_register_access_slave;
    import serial_access_pkg::*;
    localparam logic [31:0] RDV = 32'hA1B2C3D4;
    localparam logic [31:0] ERRV = 32'h88888888;
    localparam logic [31:0] CTRL_BA = 32'h71010000;
    localparam logic [31:0] PAD_BA = 32'h71010004;
    localparam logic [31:0] FAST_BA = 32'h71020040;
    localparam logic [31:0] SLOW_BA = 32'h71050080;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic siOwner = 1'b1;
    logic busAck = 1'b0;
    logic [31:0] busRdata = RDV;
    logic peerReq = 1'b0;
    wire logic serialClk;
    wire logic slaveSelectN;
    wire logic serialDataIn;
    logic serialDataOut, serialDataOutEn, busReq, peerGnt;
    regReq_t busOut;
    regReq_t lastReq = '0;
    int nFail = 0;
    int nTests = 0;
    int ackLat = 2;
    int nReq = 0;
    int cnt = 0;
    int n0;
    logic reqSeen = 1'b0;
    logic [1:0] ctrlNow = 2'h0;
    logic [31:0] rv;
    logic bad;
    logic [31:0] pat [4] = '{32'h0, 32'h81000081, 32'h42000042, 32'hC30000C3};

    serial_register_access_slave uut (.clk_sys(clk_sys), .rst(rst),
        .serialClk(serialClk), .slaveSelectN(slaveSelectN),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutEn(serialDataOutEn), .siOwner(siOwner),
        .busOut(busOut), .busReq(busReq), .busAck(busAck),
        .busRdata(busRdata), .peerReq(peerReq), .peerGnt(peerGnt));
    serial_host_model host (.serialClk(serialClk),
        .slaveSelectN(slaveSelectN), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ==========
    // Register bus target: one-cycle ack after ackLat cycles
    always @(posedge clk_sys) begin
        reqSeen <= busReq;
        if (busReq && !reqSeen) begin
            nReq <= nReq + 1;
            lastReq <= busOut;
        end
        if (busAck) begin
            busAck <= 1'b0;
            cnt <= 0;
        end else if (busReq) begin
            busAck <= (cnt == ackLat);
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
    end

    // ==========
    // Helpers
    function automatic logic [31:0] mapw(input logic [31:0] v,
        input logic [1:0] c);
        logic [31:0] r;
        r = c[0] ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
        if (c[1]) r = {<<{r}};
        return r;
    endfunction
    function automatic logic [21:0] wa(input logic [31:0] a);
        return 22'((a & 32'h00FFFFFF) >> 2);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        nTests++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        host.xfer(1'b0, wa(a), mapw(v, ctrlNow), 0, 56, 0, rv, bad);
        chk({31'h0, bad}, 32'h0, "enable on write");
        repeat (8) @(posedge clk_sys);
    endtask
    // Local words come back mapped; the error word never is
    task automatic rc(input logic [31:0] a, input int pad, input int ps,
        input logic [31:0] exp, input string what);
        host.xfer(1'b1, wa(a), 32'h0, pad, 999, ps, rv, bad);
        chk({31'h0, bad}, 32'h0, "enable on read");
        chk(rv, mapw(exp, ctrlNow), what);
    endtask
    task automatic finishTest();
        if (nFail == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========
    // Tests
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rc(CTRL_BA, 0, 1000, 32'h0, "ctrl reset");
        rc(PAD_BA, 0, 1000, 32'h0, "pad reset");
        for (int c = 0; c < 4; c++) begin
            wr(CTRL_BA, pat[c]);
            ctrlNow = c[1:0];
            rc(CTRL_BA, 0, 1000, {30'h0, c[1:0]}, "ctrl");
            wr(SLOW_BA, 32'h0F1E2D3C);
            chk(lastReq.wdata, 32'h0F1E2D3C, "wdata");
            chk({9'h0, lastReq.we, lastReq.addr}, 32'h00414020, "addr");
            rc(FAST_BA, 0, 1000, RDV, "fast read");
        end
        wr(CTRL_BA, 32'h0);
        ctrlNow = 2'h0;
        wr(CTRL_BA, 32'h80000000);
        ctrlNow = 2'h1;
        rc(CTRL_BA, 0, 1000, 32'h1, "ctrl one bit");
        wr(CTRL_BA, 32'h0);
        ctrlNow = 2'h0;
        ackLat = 30;
        host.halfNs = 1000;
        rc(SLOW_BA, 0, 0, RDV, "slow clock");
        host.halfNs = 40;
        wr(PAD_BA, 32'h1);
        ackLat = 2;
        rc(FAST_BA, 1, 0, RDV, "padded");
        ackLat = 30;
        rc(SLOW_BA, 1, 0, ERRV, "late data");
        rc(PAD_BA, 1, 0, 32'h00010001, "sticky");
        wr(PAD_BA, 32'h00010001);
        rc(PAD_BA, 1, 0, 32'h1, "cleared");
        wr(PAD_BA, 32'h0);
        ackLat = 60;
        rc(SLOW_BA, 0, 3000, ERRV, "slow timeout");
        ackLat = 6;
        rc(FAST_BA, 0, 1000, ERRV, "fast timeout");
        ackLat = 2;
        n0 = nReq;
        host.xfer(1'b0, wa(SLOW_BA), 32'h5, 0, 55, 0, rv, bad);
        repeat (10) @(posedge clk_sys);
        chk(nReq, n0, "aborted");
        host.noise(40);
        repeat (10) @(posedge clk_sys);
        chk(nReq, n0, "idle pins");
        @(posedge clk_sys) siOwner <= 1'b0;
        repeat (5) @(posedge clk_sys);
        wr(SLOW_BA, 32'h7);
        chk(nReq, n0, "not owner");
        @(posedge clk_sys) siOwner <= 1'b1;
        @(posedge clk_sys) peerReq <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, peerGnt}, 32'h1, "peer grant");
        wr(FAST_BA, 32'h9);
        chk(nReq, n0 + 1, "fast exempt");
        wr(SLOW_BA, 32'hA);
        repeat (20) @(posedge clk_sys);
        chk(nReq, n0 + 1, "slow waits");
        @(posedge clk_sys) peerReq <= 1'b0;
        repeat (60) @(posedge clk_sys);
        chk(nReq, n0 + 2, "slow after peer");
        chk(lastReq.wdata, 32'hA, "queued write");
        finishTest();
    end

    // A run needs well under half a millisecond
    initial begin
        #1000000;
        nFail++;
        finishTest();
    end
endmodule
`default_nettype wire
